// [rtl/gov_pkg.sv]
/*
 package for the governor discrete command logic: register map, field positions,
 reset values and timing counts. assumes a 32-bit classic wishbone slave.
*/
package gov_pkg;
    localparam logic [7:0]  ADDR_CTRL      = 8'h00;
    localparam logic [7:0]  ADDR_STATUS    = 8'h04;
    localparam logic [7:0]  ADDR_RATE      = 8'h08;
    localparam logic [7:0]  ADDR_LIMIT     = 8'h0C;
    localparam logic [7:0]  ADDR_REF       = 8'h10;
    localparam logic [7:0]  ADDR_DROOP     = 8'h14;
    localparam logic [7:0]  ADDR_FUEL      = 8'h18;
    localparam logic [7:0]  ADDR_DEMAND    = 8'h1C;
    localparam logic [7:0]  ADDR_ALARM     = 8'h20;
    localparam logic [7:0]  ADDR_BIAS      = 8'h24;
    localparam int          CTRL_SW_RESET  = 0;
    localparam int          CTRL_REVERSE   = 1;
    localparam int          ST_ISOCH       = 0;
    localparam int          ST_RESET       = 1;
    localparam int          ST_OVERRIDE    = 2;
    localparam int          ST_DYN2        = 3;
    localparam int          ST_RAISE       = 4;
    localparam int          ST_RATED       = 5;
    localparam int          ST_SHUTDOWN    = 6;
    localparam logic [15:0] RATE_RST       = 16'h0001;
    localparam logic [15:0] LIMIT_RST      = 16'hFFFF;
    localparam logic [15:0] REF_RST        = 16'h0000;
    localparam logic [15:0] DROOP_RST      = 16'h0000;
    localparam int          RESET_PULSE_NS = 100;
    localparam int          CLK_NS         = 10;
    localparam int          RESET_PULSE_CY = RESET_PULSE_NS / CLK_NS;
    localparam logic [31:0] BAD_ADDR_DATA  = 32'h0000_0000;
endpackage : gov_pkg

// [rtl/pin_sync.sv]
/*
 two-flop synchroniser for a vector of contact inputs.
 assumes inputs are asynchronous to clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int W = 5
) (
    input  wire logic         clk_sys,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync_out
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] sync_r;
    logic [W-1:0] sync_nxt;

    always_comb begin
        meta_nxt = clk_en ? pin_in : meta_r;
        sync_nxt = clk_en ? meta_r : sync_r;
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign pin_sync_out = sync_r;
endmodule : pin_sync
`default_nettype wire

// [rtl/gov_discrete.sv]
/*
 governor discrete command logic: five contact inputs drive droop/isochronous,
 alarm reset one-shot, speed-fail override, dynamics select and raise ramp.
 assumes contact pins are asynchronous, software on classic wishbone.
*/
// Decided for this implementation: the register offsets and the Wishbone register port.
// Notes on behaviour
// RL1 - input TRUE while contact closed
// RL2 - isochronous FALSE selects droop from fuel
// RL3 - isochronous TRUE follows load-sharing bias
// RL4 - outside opens breaker aux when droop
// RL5 - reset clears only alarms now normal
// RL6 - alarm reset acts briefly despite held contact
// RL7 - rearm only after input returns FALSE
// RL8 - OR reset with serial ports, software
// RL9 - override suppresses speed-loss shutdown
// RL10 - no override: shutdown when both sensors lost
// RL11 - reverse acting override drives fuel upward
// RL12 - direct acting: override kept open
// RL13 - dynamics input selects second set
// RL14 - raise ramps reference at set rate
// RL15 - raised reference clamped at limit
// RL16 - stop raising when input FALSE
// RL17 - raise ignored without rated speed
// RL18 - droop raise increases fuel and load
// RL19 - no raise with breaker and load sharing
// RL20 - sync inputs, edge-detect reset
`timescale 1ns/1ps
`default_nettype none
module gov_discrete #(
    parameter int ALARMS = 8,
    parameter int RW     = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              clk_en,
    input  wire logic              isoch_pin,
    input  wire logic              alarm_reset_pin,
    input  wire logic              override_pin,
    input  wire logic              dyn2_pin,
    input  wire logic              raise_pin,
    input  wire logic              rated_sel,
    input  wire logic              serial_port_one_reset,
    input  wire logic              serial_port_two_reset,
    input  wire logic              speed_lost_a,
    input  wire logic              speed_lost_b,
    input  wire logic [ALARMS-1:0] alarm_event,
    input  wire logic [ALARMS-1:0] alarm_cond,
    input  wire logic [31:0]       wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic              wb_we_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   droop_mode,
    output logic                   bias_follow,
    output logic                   alarm_reset_pulse,
    output logic      [ALARMS-1:0] alarm_latched,
    output logic                   shutdown,
    output logic                   fuel_force_up,
    output logic                   dyn2_sel,
    output logic      [RW-1:0]     speed_ref,
    output logic      [RW-1:0]     fuel_demand
);
    logic [4:0] pins_s;
    logic       isoch_s;
    logic       rst_s;
    logic       ovr_s;
    logic       dyn_s;
    logic       raise_s;

    pin_sync #(.W(5)) u_sync (
        .clk_sys      (clk_sys),
        .reset_n      (reset_n),
        .clk_en       (clk_en),
        .pin_in       ({raise_pin, dyn2_pin, override_pin, alarm_reset_pin, isoch_pin}),
        .pin_sync_out (pins_s)
    ); // RL1 RL20

    assign isoch_s = pins_s[0];
    assign rst_s   = pins_s[1];
    assign ovr_s   = pins_s[2];
    assign dyn_s   = pins_s[3];
    assign raise_s = pins_s[4];

    // software registers
    logic [1:0]        ctrl_r, ctrl_nxt;
    logic [RW-1:0]     rate_r, rate_nxt;
    logic [RW-1:0]     limit_r, limit_nxt;
    logic [RW-1:0]     droop_r, droop_nxt;
    logic [RW-1:0]     fuel_base_r, fuel_base_nxt;
    logic [RW-1:0]     bias_r, bias_nxt;
    logic [31:0]       dat_r, dat_nxt;
    logic              ack_r, ack_nxt;
    logic              wr_go;
    logic              sw_reset_req;

    // alarm reset one-shot
    typedef enum logic [1:0] {
        RS_IDLE  = 2'b00,
        RS_PULSE = 2'b01,
        RS_HOLD  = 2'b10
    } rst_state_t;
    rst_state_t        rs_r, rs_nxt;
    logic [7:0]        rcnt_r, rcnt_nxt;
    logic              rst_prev_r, rst_prev_nxt;
    logic              serial_prev_r, serial_prev_nxt;
    logic              pulse_r, pulse_nxt;
    logic [ALARMS-1:0] clr_mask_r, clr_mask_nxt;
    logic [ALARMS-1:0] alarm_r, alarm_nxt;
    logic              other_edge;

    // outputs and ramp
    logic [RW-1:0]     ref_r, ref_nxt;
    logic [RW-1:0]     fuel_r, fuel_nxt;
    logic              droop_r2, droop_nxt2;
    logic              bias_r2, bias_nxt2;
    logic              shut_r, shut_nxt;
    logic              force_r, force_nxt;
    logic              dyn_r, dyn_nxt;
    logic [RW:0]       ref_sum;
    logic [RW+1:0]     fuel_sum;

    assign wr_go        = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r;
    assign sw_reset_req = wr_go && wb_adr_i[7:0] == gov_pkg::ADDR_CTRL && wb_sel_i[0]
                          && wb_dat_i[gov_pkg::CTRL_SW_RESET];

    always_comb begin
        ctrl_nxt      = ctrl_r;
        rate_nxt      = rate_r;
        limit_nxt     = limit_r;
        droop_nxt     = droop_r;
        fuel_base_nxt = fuel_base_r;
        bias_nxt      = bias_r;
        dat_nxt       = dat_r;
        ack_nxt       = 1'b0;
        if (clk_en && wb_cyc_i && wb_stb_i && !ack_r) begin
            ack_nxt = 1'b1;
            dat_nxt = gov_pkg::BAD_ADDR_DATA;
            if (wb_we_i) begin
                unique case (wb_adr_i[7:0])
                    gov_pkg::ADDR_CTRL:   ctrl_nxt[gov_pkg::CTRL_REVERSE] = wb_dat_i[gov_pkg::CTRL_REVERSE];
                    gov_pkg::ADDR_RATE:   rate_nxt = wb_dat_i[RW-1:0];
                    gov_pkg::ADDR_LIMIT:  limit_nxt = wb_dat_i[RW-1:0];
                    gov_pkg::ADDR_DROOP:  droop_nxt = wb_dat_i[RW-1:0];
                    gov_pkg::ADDR_FUEL:   fuel_base_nxt = wb_dat_i[RW-1:0];
                    gov_pkg::ADDR_BIAS:   bias_nxt = wb_dat_i[RW-1:0];
                    default: ;
                endcase
            end else begin
                unique case (wb_adr_i[7:0])
                    gov_pkg::ADDR_CTRL:   dat_nxt = {30'h0, ctrl_r};
                    gov_pkg::ADDR_STATUS: dat_nxt = {25'h0, shut_r, rated_sel, raise_s, dyn_s, ovr_s,
                                                     rst_s, isoch_s};
                    gov_pkg::ADDR_RATE:   dat_nxt = 32'(rate_r);
                    gov_pkg::ADDR_LIMIT:  dat_nxt = 32'(limit_r);
                    gov_pkg::ADDR_REF:    dat_nxt = 32'(ref_r);
                    gov_pkg::ADDR_DROOP:  dat_nxt = 32'(droop_r);
                    gov_pkg::ADDR_FUEL:   dat_nxt = 32'(fuel_base_r);
                    gov_pkg::ADDR_DEMAND: dat_nxt = 32'(fuel_r);
                    gov_pkg::ADDR_ALARM:  dat_nxt = 32'(alarm_r);
                    gov_pkg::ADDR_BIAS:   dat_nxt = 32'(bias_r);
                    default: ;
                endcase
            end
        end
    end

    always_comb begin
        rs_nxt          = rs_r;
        rcnt_nxt        = rcnt_r;
        rst_prev_nxt    = rst_prev_r;
        serial_prev_nxt = serial_prev_r;
        pulse_nxt       = pulse_r;
        clr_mask_nxt    = clr_mask_r;
        alarm_nxt       = alarm_r;
        other_edge      = 1'b0;
        if (clk_en) begin
            rst_prev_nxt    = rst_s;
            serial_prev_nxt = serial_port_one_reset | serial_port_two_reset;
            other_edge      = (serial_prev_nxt && !serial_prev_r) || sw_reset_req; // RL8
            pulse_nxt       = 1'b0;
            unique case (rs_r)
                RS_IDLE: begin
                    if ((rst_s && !rst_prev_r) || other_edge) begin // RL20 RL8
                        rs_nxt       = RS_PULSE;
                        rcnt_nxt     = 8'(gov_pkg::RESET_PULSE_CY - 1);
                        pulse_nxt    = 1'b1;
                        clr_mask_nxt = ~alarm_cond; // RL5
                    end
                end
                RS_PULSE: begin
                    pulse_nxt = rcnt_r != 8'h00;
                    rcnt_nxt  = rcnt_r - 8'h01;
                    if (rcnt_r == 8'h00) begin
                        rs_nxt = RS_HOLD; // RL6
                    end
                end
                RS_HOLD: begin
                    if (!rst_s) begin
                        rs_nxt = RS_IDLE; // RL7
                    end
                end
                default: rs_nxt = RS_IDLE;
            endcase
            alarm_nxt = (alarm_r & ~(pulse_r ? clr_mask_r : '0)) | alarm_event; // RL5
        end
    end

    assign ref_sum  = {1'b0, ref_r} + {1'b0, rate_r};
    assign fuel_sum = {2'b00, fuel_base_r} + {2'b00, (isoch_s ? bias_r : droop_r)} + {2'b00, ref_r};

    always_comb begin
        ref_nxt    = ref_r;
        fuel_nxt   = fuel_r;
        droop_nxt2 = droop_r2;
        bias_nxt2  = bias_r2;
        shut_nxt   = shut_r;
        force_nxt  = force_r;
        dyn_nxt    = dyn_r;
        if (clk_en) begin
            droop_nxt2 = !isoch_s; // RL2
            bias_nxt2  = isoch_s; // RL3
            dyn_nxt    = dyn_s; // RL13
            shut_nxt   = !ovr_s && speed_lost_a && speed_lost_b; // RL9 RL10
            force_nxt  = ovr_s && ctrl_r[gov_pkg::CTRL_REVERSE] && (speed_lost_a || speed_lost_b); // RL11
            if (raise_s && rated_sel) begin // RL14 RL16 RL17
                ref_nxt = (ref_sum > {1'b0, limit_r}) ? limit_r : ref_sum[RW-1:0]; // RL15
            end
            if (shut_r) begin
                fuel_nxt = '0;
            end else if (force_r) begin
                fuel_nxt = '1; // RL11
            end else begin
                // droop or bias term and raise ref both lift demand
                fuel_nxt = (fuel_sum[RW+1:RW] != 2'b00) ? '1 : fuel_sum[RW-1:0]; // RL2 RL3 RL18
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_r        <= 2'b00;
            rate_r        <= gov_pkg::RATE_RST;
            limit_r       <= gov_pkg::LIMIT_RST;
            droop_r       <= gov_pkg::DROOP_RST;
            fuel_base_r   <= '0;
            bias_r        <= '0;
            dat_r         <= 32'h0000_0000;
            ack_r         <= 1'b0;
            rs_r          <= RS_IDLE;
            rcnt_r        <= 8'h00;
            rst_prev_r    <= 1'b0;
            serial_prev_r <= 1'b0;
            pulse_r       <= 1'b0;
            clr_mask_r    <= '0;
            alarm_r       <= '0;
            ref_r         <= gov_pkg::REF_RST;
            fuel_r        <= '0;
            droop_r2      <= 1'b1;
            bias_r2       <= 1'b0;
            shut_r        <= 1'b0;
            force_r       <= 1'b0;
            dyn_r         <= 1'b0;
        end else begin
            ctrl_r        <= ctrl_nxt;
            rate_r        <= rate_nxt;
            limit_r       <= limit_nxt;
            droop_r       <= droop_nxt;
            fuel_base_r   <= fuel_base_nxt;
            bias_r        <= bias_nxt;
            dat_r         <= dat_nxt;
            ack_r         <= ack_nxt;
            rs_r          <= rs_nxt;
            rcnt_r        <= rcnt_nxt;
            rst_prev_r    <= rst_prev_nxt;
            serial_prev_r <= serial_prev_nxt;
            pulse_r       <= pulse_nxt;
            clr_mask_r    <= clr_mask_nxt;
            alarm_r       <= alarm_nxt;
            ref_r         <= ref_nxt;
            fuel_r        <= fuel_nxt;
            droop_r2      <= droop_nxt2;
            bias_r2       <= bias_nxt2;
            shut_r        <= shut_nxt;
            force_r       <= force_nxt;
            dyn_r         <= dyn_nxt;
        end
    end

    assign wb_dat_o          = dat_r;
    assign wb_ack_o          = ack_r;
    assign droop_mode        = droop_r2;
    assign bias_follow       = bias_r2;
    assign alarm_reset_pulse = pulse_r;
    assign alarm_latched     = alarm_r;
    assign shutdown          = shut_r;
    assign fuel_force_up     = force_r;
    assign dyn2_sel          = dyn_r;
    assign speed_ref         = ref_r;
    assign fuel_demand       = fuel_r;

    // checks
    int unsigned pulse_len_r;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pulse_len_r <= 0;
        end else begin
            pulse_len_r <= pulse_r ? pulse_len_r + 1 : 0;
        end
    end

    sequence rst_rise_s;
        clk_en && rst_s && !rst_prev_r && rs_r == RS_IDLE;
    endsequence

    sequence pulse_seen_s;
        ##1 pulse_r;
    endsequence

    droop_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> droop_mode == !$past(isoch_s)) else $error("droop select wrong"); // RL2
    bias_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> bias_follow == $past(isoch_s)) else $error("bias follow wrong"); // RL3
    reset_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rst_rise_s |-> pulse_seen_s) else $error("reset edge gave no pulse"); // RL20
    pulse_short_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        pulse_len_r <= gov_pkg::RESET_PULSE_CY) else $error("reset pulse too long"); // RL6
    rearm_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rs_r == RS_HOLD && rst_s |=> rs_r == RS_HOLD) else $error("rearm while held"); // RL7
    override_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && ovr_s |=> !shutdown) else $error("shutdown under override"); // RL9
    both_lost_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && !ovr_s && !(speed_lost_a && speed_lost_b) |=> !shutdown) else $error("shutdown one sensor"); // RL10
    dyn_sel_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> dyn2_sel == $past(dyn_s)) else $error("dynamics select wrong"); // RL13
    raise_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(raise_s && rated_sel) |=> $stable(speed_ref)) else $error("ref moved without raise"); // RL16
    clamp_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
        clk_en && raise_s && rated_sel |=> speed_ref <= $past(limit_r)) else $error("ref over limit"); // RL15
endmodule : gov_discrete
`default_nettype wire

// [sim/contact_bank.sv]
/*
 model of the plant contacts that feed the five discrete inputs.
 assumes commands come from the bench on clk_sys.
*/
`timescale 1ns/1ps
`default_nettype none
module contact_bank (
    input  wire logic       clk_sys,
    input  wire logic [4:0] close_cmd,
    input  wire logic       direct_running,
    output logic            isoch_pin,
    output logic            alarm_reset_pin,
    output logic            override_pin,
    output logic            dyn2_pin,
    output logic            raise_pin,
    output logic            breaker_aux_input
);
    initial {isoch_pin, alarm_reset_pin, override_pin, dyn2_pin, raise_pin, breaker_aux_input} = 6'h00;
    // contacts settle one edge after a command
    always @(posedge clk_sys) begin
        isoch_pin         <= close_cmd[0];
        alarm_reset_pin   <= close_cmd[1];
        override_pin      <= close_cmd[2] & ~direct_running;
        dyn2_pin          <= close_cmd[3];
        raise_pin         <= close_cmd[4] & ~close_cmd[0];
        breaker_aux_input <= close_cmd[0];
    end
endmodule : contact_bank
`default_nettype wire

// [sim/testbench.sv]
/*
 self-checking bench for gov_discrete: reset values, then pin table, alarm reset and raise.
 assumes contact_bank drives the contact pins.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct packed {
        logic [5:0]  stim;
        logic [4:0]  flags;
        logic [15:0] fuel;
    } row_t;
    logic        clk_sys, reset_n, rated_sel, speed_lost_a, speed_lost_b, direct_running;
    logic        serial_port_one_reset, serial_port_two_reset;
    logic [4:0]  close_cmd;
    logic        isoch_pin, alarm_reset_pin, override_pin, dyn2_pin, raise_pin, breaker_aux_input;
    logic [7:0]  alarm_event, alarm_cond, alarm_latched;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    logic [3:0]  wb_sel_i;
    logic        wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
    logic        droop_mode, bias_follow, alarm_reset_pulse, shutdown, fuel_force_up, dyn2_sel;
    logic [15:0] speed_ref, fuel_demand, ref_a;
    int          fail_count = 0;
    int          samples_checked = 0;
    int          pulse_total = 0;
    int          n;
    row_t        rows [9];

    contact_bank u_contacts (.clk_sys(clk_sys), .close_cmd(close_cmd), .direct_running(direct_running),
        .isoch_pin(isoch_pin), .alarm_reset_pin(alarm_reset_pin), .override_pin(override_pin),
        .dyn2_pin(dyn2_pin), .raise_pin(raise_pin), .breaker_aux_input(breaker_aux_input));

    gov_discrete u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(1'b1), .isoch_pin(isoch_pin),
        .alarm_reset_pin(alarm_reset_pin), .override_pin(override_pin), .dyn2_pin(dyn2_pin),
        .raise_pin(raise_pin), .rated_sel(rated_sel), .serial_port_one_reset(serial_port_one_reset),
        .serial_port_two_reset(serial_port_two_reset), .speed_lost_a(speed_lost_a),
        .speed_lost_b(speed_lost_b), .alarm_event(alarm_event), .alarm_cond(alarm_cond),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .droop_mode(droop_mode), .bias_follow(bias_follow), .alarm_reset_pulse(alarm_reset_pulse),
        .alarm_latched(alarm_latched), .shutdown(shutdown), .fuel_force_up(fuel_force_up),
        .dyn2_sel(dyn2_sel), .speed_ref(speed_ref), .fuel_demand(fuel_demand));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // counts cycles with the reset pulse high
    always @(posedge clk_sys) begin
        if (alarm_reset_pulse === 1'b1) pulse_total <= pulse_total + 1;
    end

    task automatic print_verdict();
        if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb_xfer(input logic [7:0] adr, input logic we, input logic [31:0] wd);
        int k;
        wb_adr_i <= {24'h000000, adr};
        wb_we_i  <= we;
        wb_dat_i <= wd;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (wb_ack_o !== 1'b1) begin
            fail_count++;
            print_verdict();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        wb_xfer(adr, 1'b1, wd);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        wb_xfer(adr, 1'b0, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_chk

    task automatic alarm_case(input int src, input logic [7:0] cond);
        int base_cnt;
        alarm_event <= 8'hFF;
        alarm_cond  <= cond;
        @(posedge clk_sys);
        alarm_event <= 8'h00;
        repeat (2) @(posedge clk_sys);
        base_cnt = pulse_total;
        case (src)
            0: close_cmd[1] <= 1'b1;
            1: serial_port_one_reset <= 1'b1;
            2: serial_port_two_reset <= 1'b1;
            default: wr(gov_pkg::ADDR_CTRL, 32'h0000_0001);
        endcase
        repeat (40) @(posedge clk_sys);
        check(pulse_total - base_cnt, gov_pkg::RESET_PULSE_CY);
        check({24'h000000, alarm_latched}, {24'h000000, cond});
        close_cmd[1]          <= 1'b0;
        serial_port_one_reset <= 1'b0;
        serial_port_two_reset <= 1'b0;
        repeat (8) @(posedge clk_sys);
    endtask : alarm_case

    initial begin
        rows = '{'{6'h00, 5'h10, 16'h0110}, '{6'h20, 5'h08, 16'h0120}, '{6'h08, 5'h14, 16'h0110},
                 '{6'h04, 5'h10, 16'h0110}, '{6'h06, 5'h12, 16'h0000}, '{6'h16, 5'h10, 16'h0110},
                 '{6'h15, 5'h11, 16'hFFFF}, '{6'h11, 5'h10, 16'h0110}, '{6'h28, 5'h0C, 16'h0120}};
        {reset_n, rated_sel, speed_lost_a, speed_lost_b, direct_running} = 5'h00;
        {serial_port_one_reset, serial_port_two_reset, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h00;
        {close_cmd, alarm_event, alarm_cond} = 21'h000000;
        {wb_adr_i, wb_dat_i} = 64'h0;
        wb_sel_i = 4'hF;
        repeat (5) @(posedge clk_sys);
        check({27'h0, droop_mode, bias_follow, shutdown, fuel_force_up, dyn2_sel}, 32'h10);
        check({alarm_reset_pulse, alarm_latched, speed_ref}, 32'h0);
        check({15'h0, wb_ack_o, fuel_demand}, 32'h0);
        @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk(gov_pkg::ADDR_RATE, {16'h0000, gov_pkg::RATE_RST});
        rd_chk(gov_pkg::ADDR_LIMIT, {16'h0000, gov_pkg::LIMIT_RST});
        rd_chk(gov_pkg::ADDR_REF, {16'h0000, gov_pkg::REF_RST});
        rd_chk(gov_pkg::ADDR_DROOP, {16'h0000, gov_pkg::DROOP_RST});
        wr(8'h3C, 32'h0000_0055);
        rd_chk(8'h3C, gov_pkg::BAD_ADDR_DATA);
        wr(gov_pkg::ADDR_FUEL, 32'h0000_0100);
        wr(gov_pkg::ADDR_DROOP, 32'h0000_0010);
        wr(gov_pkg::ADDR_BIAS, 32'h0000_0020);
        foreach (rows[i]) begin
            close_cmd    <= {1'b0, rows[i].stim[3], rows[i].stim[4], 1'b0, rows[i].stim[5]};
            speed_lost_a <= rows[i].stim[2];
            speed_lost_b <= rows[i].stim[1];
            wr(gov_pkg::ADDR_CTRL, {30'h0, rows[i].stim[0], 1'b0});
            repeat (8) @(posedge clk_sys);
            check({27'h0, droop_mode, bias_follow, dyn2_sel, shutdown, fuel_force_up}, {27'h0, rows[i].flags});
            check({16'h0, fuel_demand}, {16'h0, rows[i].fuel});
            check({31'h0, breaker_aux_input}, {31'h0, rows[i].stim[5]});
        end
        {close_cmd, speed_lost_a, speed_lost_b} <= 7'h00;
        alarm_case(0, 8'h0A);
        alarm_case(0, 8'h00);
        alarm_case(1, 8'h81);
        alarm_case(2, 8'h00);
        alarm_case(3, 8'h10);
        wr(gov_pkg::ADDR_RATE, 32'h0000_0003);
        wr(gov_pkg::ADDR_LIMIT, 32'h0000_0020);
        close_cmd <= 5'h10;
        repeat (20) @(posedge clk_sys);
        rd_chk(gov_pkg::ADDR_REF, 32'h0000_0000);
        rated_sel <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (speed_ref === 16'h0000 && n < 20);
        if (speed_ref === 16'h0000) begin
            fail_count++;
            print_verdict();
        end
        ref_a = speed_ref;
        @(posedge clk_sys);
        check({16'h0, speed_ref - ref_a}, 32'h3);
        repeat (20) @(posedge clk_sys);
        check({16'h0, speed_ref}, 32'h20);
        check({16'h0, fuel_demand}, 32'h130);
        wr(gov_pkg::ADDR_LIMIT, 32'h0000_FFFF);
        repeat (4) @(posedge clk_sys);
        close_cmd <= 5'h00;
        repeat (6) @(posedge clk_sys);
        ref_a = speed_ref;
        check({31'h0, ref_a > 16'h0020}, 32'h1);
        repeat (10) @(posedge clk_sys);
        check({16'h0, speed_ref}, {16'h0, ref_a});
        rd_chk(gov_pkg::ADDR_STATUS, 32'h0000_0020);
        rd_chk(gov_pkg::ADDR_DEMAND, {16'h0, 16'h0110 + ref_a});
        rd_chk(gov_pkg::ADDR_ALARM, 32'h0000_0010);
        rd_chk(gov_pkg::ADDR_BIAS, 32'h0000_0020);
        // direct acting plant keeps the override contact open
        direct_running <= 1'b1;
        {close_cmd, speed_lost_a, speed_lost_b} <= 7'h13;
        repeat (8) @(posedge clk_sys);
        check({15'h0, shutdown, fuel_demand}, 32'h0001_0000);
        {close_cmd, speed_lost_a, speed_lost_b, direct_running} <= 8'h00;
        // reset in mid-run
        reset_n <= 1'b0;
        @(posedge clk_sys);
        check({15'h0, wb_ack_o, fuel_demand}, 32'h0);
        check({alarm_reset_pulse, alarm_latched, speed_ref}, 32'h0);
        check({27'h0, droop_mode, bias_follow, shutdown, fuel_force_up, dyn2_sel}, 32'h10);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk(gov_pkg::ADDR_RATE, {16'h0000, gov_pkg::RATE_RST});
        rd_chk(gov_pkg::ADDR_LIMIT, {16'h0000, gov_pkg::LIMIT_RST});
        print_verdict();
    end
endmodule : testbench
`default_nettype wire
